/* File: wsv_supervisor.sv */
// watchdog error counting, reset and power-down supervisor
//
// How it works
// - current question is zero after reset, moves on only after a correct answer
// - response payload byte is taken as byte 3,2,1,0 by the byte counter
// - short mode walks 16 questions, distance at least 3 between neighbours
// - long mode repeats question order only after 256 questions
// - each question has four fixed expected bytes, compared on arrival
// - any watchdog error marks pending, total count rises at next heartbeat
// - sync answer with functional or window error raises total count
// - heartbeat sync command always raises total count
// - total count falls only on clean sync answer; steps are configurable
// - reset counter adds exactly one on any monitoring counter overflow
// - each reset counter change issues a watchdog reset, if enabled
// - reset counter halts when disabled or full; no resets when full
// - three power-down counters each add one on their own overflow
// - software reset adds one to all three power-down counters
// - power-down counters clear when the ready state is entered
// - power-down counter overflow with ignition low forces power-down
// - shut-off timer held while ignition high, started by overflow
// - any counter above 32 gives safe state, outputs and enables off
// - all counters below 33 give ready state, monitor and reset high
// - overflow gives watchdog reset; if enabled reset low, counters clear
// - monitoring counters hold value instead of wrapping either way
// - shut-off time is 20 minutes nominal
// - heartbeat from timer expiry, period sync, or sync answer byte 0
`timescale 1ns/1ps
module wsv_supervisor #(
   parameter logic [wsv_pkg::SECURE_SHUTOFF_TIMER_W-1:0] SECURE_SHUTOFF_TIMER_CYCLES =
      wsv_pkg::SECURE_SHUTOFF_TIMER_W'(wsv_pkg::SECURE_SHUTOFF_TIMER_CYC)
) (
   input  wire logic        i_clk,
   input  wire logic        i_srst,
   input  wire logic        i_hsel,
   input  wire logic [31:0] i_haddr,
   input  wire logic [1:0]  i_htrans,
   input  wire logic        i_hwrite,
   input  wire logic [2:0]  i_hsize,
   input  wire logic [31:0] i_hwdata,
   input  wire logic        i_hready,
   output logic             o_hreadyout,
   output logic             o_hresp,
   output logic [31:0]      o_hrdata,
   input  wire logic        i_ignition,
   input  wire logic        i_sw_reset,
   input  wire logic        i_hb_expire,
   input  wire logic        i_window_error,
   input  wire logic        i_window_pass,
   output logic             o_monitor,
   output logic             o_reset_n,
   output logic             o_stage_off,
   output logic             o_powerdown
);

   // ==========================================================
   // state
   typedef struct packed {
      logic                      ready;
      logic                      hresp;
      logic [31:0]               rdata;
      logic                      wr_pend;
      logic [7:0]                wr_addr;
      logic [1:0]                cfg_b;
      logic [31:0]               tec_cfg;
      logic [31:0]               mon_cfg;
      logic [7:0]                q_seq;
      logic [1:0]                resp_cnt;
      logic                      resp_err;
      wsv_pkg::wsv_chk_t         chk;
      logic [5:0]                window_error_count;
      logic [5:0]                functional_pass_count;
      logic [5:0]                total_error_count;
      logic [2:0]                rst_cnt;
      logic [2:0]                pd_w;
      logic [2:0]                pd_f;
      logic [2:0]                pd_t;
      logic                      secure_shutoff_timer_run;
      logic [wsv_pkg::SECURE_SHUTOFF_TIMER_W-1:0] secure_shutoff_timer_cnt;
      logic [wsv_pkg::RT_W-1:0]  rst_tmr;
      wsv_pkg::wsv_op_t          op;
      logic                      monitor;
      logic                      reset_n;
      logic                      stage_off;
      logic                      pwrdn;
   } wsv_state_t;

   wsv_state_t s_q;
   wsv_state_t s_d;

   logic       acc;
   logic       cmd_r;
   logic       cmd_s;
   logic       cmd_h;
   logic [3:0] cur_q;
   logic [7:0] exp_b;
   logic       byte0;
   logic       bad;
   logic       fwd_err;
   logic       fwd_pass;
   logic       wwd_err;
   logic       hb;
   logic       tec_inc;
   logic       tec_dec;
   logic [6:0] up_w;
   logic [6:0] up_f;
   logic [6:0] up_t;
   logic       any_ovf;
   logic       do_rst;
   logic [3:0] pw;
   logic [3:0] pf;
   logic [3:0] pt;
   logic       pd_ovf;
   logic       secure_shutoff_timer_exp;

   // ==========================================================
   // non-wrapping steps; an up or down step that would wrap keeps the old value
   function automatic logic [6:0] f_up(input logic [5:0] c,
                                       input logic [5:0] s);
      logic [6:0] t;
      t = {1'b0, c} + {1'b0, s};
      f_up = t[6] ? {1'b1, c} : t;
   endfunction

   function automatic logic [5:0] f_dn(input logic [5:0] c,
                                       input logic [5:0] s);
      f_dn = (s > c) ? c : 6'(c - s);
   endfunction

   function automatic logic [3:0] f_pd(input logic [2:0] c);
      f_pd = (c == wsv_pkg::PD_FULL) ? {1'b1, c} : {1'b0, 3'(c + 3'h1)};
   endfunction

   // ==========================================================
   // next state
   always_comb begin
      s_d = s_q;

      // ==========================================================
      // question select; long mode offsets each block of 16
      if (s_q.cfg_b[wsv_pkg::CFG_QG]) begin
         cur_q = 4'(s_q.q_seq[3:0] + s_q.q_seq[7:4]);
      end else begin
         cur_q = wsv_pkg::QSEQ[s_q.q_seq[3:0]];
      end

      // ==========================================================
      // bus: zero wait, read data latched in the address phase
      acc = i_hsel & i_htrans[1] & i_hready & (i_hsize == wsv_pkg::HSIZE_W);
      s_d.wr_pend = acc & i_hwrite;
      s_d.wr_addr = i_haddr[7:0];
      s_d.ready   = 1'b1;
      s_d.hresp   = 1'b0;
      if (acc & ~i_hwrite) begin
         unique case (i_haddr[7:0])
            wsv_pkg::A_CFGB:  s_d.rdata = {30'h0, s_q.cfg_b};
            wsv_pkg::A_TECFG: s_d.rdata = s_q.tec_cfg;
            wsv_pkg::A_MNCFG: s_d.rdata = s_q.mon_cfg;
            wsv_pkg::A_FSTB:  s_d.rdata = {26'h0, s_q.resp_cnt, cur_q};
            wsv_pkg::A_TEST:  s_d.rdata = {26'h0, s_q.total_error_count};
            wsv_pkg::A_STA:   s_d.rdata = {10'h0, s_q.functional_pass_count, 2'h0,
                                           s_q.window_error_count, 1'b0, s_q.pd_w,
                                           1'b0, s_q.rst_cnt};
            wsv_pkg::A_STB:   s_d.rdata = {21'h0, s_q.secure_shutoff_timer_run, s_q.op,
                                           1'b0, s_q.pd_t, 1'b0,
                                           s_q.pd_f};
            default:          s_d.rdata = 32'h0000_0000;
         endcase
      end

      // ==========================================================
      // commands and configuration writes, one cycle after the address
      cmd_r = s_q.wr_pend & (s_q.wr_addr == wsv_pkg::A_RESP);
      cmd_s = s_q.wr_pend & (s_q.wr_addr == wsv_pkg::A_RSYNC);
      cmd_h = s_q.wr_pend & (s_q.wr_addr == wsv_pkg::A_HSYNC);
      if (s_q.wr_pend & (s_q.wr_addr == wsv_pkg::A_CFGB)) begin
         s_d.cfg_b = i_hwdata[1:0];
      end
      if (s_q.wr_pend & (s_q.wr_addr == wsv_pkg::A_TECFG)) begin
         s_d.tec_cfg = i_hwdata & wsv_pkg::TEC_MASK;
      end
      if (s_q.wr_pend & (s_q.wr_addr == wsv_pkg::A_MNCFG)) begin
         s_d.mon_cfg = i_hwdata & wsv_pkg::MON_MASK;
      end

      // ==========================================================
      // answer bytes arrive 3 down to 0
      exp_b = wsv_pkg::RESP_TAB[cur_q][{s_q.resp_cnt, 3'b000} +: 8];
      byte0 = (cmd_r | cmd_s) & (s_q.resp_cnt == 2'h0);
      bad   = s_q.resp_err | ((cmd_r | cmd_s) & (i_hwdata[7:0] != exp_b));
      fwd_err  = (byte0 & bad) | cmd_h;
      fwd_pass = byte0 & ~bad;
      if (cmd_r | cmd_s) begin
         if (s_q.resp_cnt == 2'h0) begin
            s_d.resp_cnt = wsv_pkg::BYTE3;
            s_d.resp_err = 1'b0;
         end else begin
            s_d.resp_cnt = 2'(s_q.resp_cnt - 2'h1);
            s_d.resp_err = bad;
         end
      end
      if (cmd_h) begin
         s_d.resp_cnt = wsv_pkg::BYTE3;
         s_d.resp_err = 1'b0;
      end
      // a failed answer keeps the same challenge for the retry
      if (fwd_pass) begin
         s_d.q_seq = 8'(s_q.q_seq + 8'h01);
      end

      // ==========================================================
      // heartbeat and total error decision
      wwd_err = i_window_error;
      hb = i_hb_expire | cmd_h | (cmd_s & byte0);
      tec_inc = (hb & ((s_q.chk == wsv_pkg::CHK_PEND) | fwd_err | wwd_err))
              | (cmd_s & byte0 & (bad | wwd_err))
              | cmd_h;
      tec_dec = cmd_s & byte0 & ~bad & ~wwd_err
              & (s_q.chk == wsv_pkg::CHK_CLEAN);
      if (hb) begin
         s_d.chk = wsv_pkg::CHK_CLEAN;
      end else if (fwd_err | wwd_err) begin
         s_d.chk = wsv_pkg::CHK_PEND;
      end

      // ==========================================================
      // six-bit monitoring counters, increment applied before decrement
      up_w = f_up(s_q.window_error_count, s_q.mon_cfg[wsv_pkg::INC_L +: 6]);
      up_f = f_up(s_q.functional_pass_count, s_q.mon_cfg[wsv_pkg::FINC_L +: 6]);
      up_t = f_up(s_q.total_error_count, s_q.tec_cfg[wsv_pkg::INC_L +: 6]);
      s_d.window_error_count = wwd_err ? up_w[5:0] : s_q.window_error_count;
      s_d.functional_pass_count = hb ? up_f[5:0] : s_q.functional_pass_count;
      s_d.total_error_count   = tec_inc ? up_t[5:0] : s_q.total_error_count;
      if (i_window_pass) begin
         s_d.window_error_count = f_dn(s_d.window_error_count, s_q.mon_cfg[wsv_pkg::DEC_L +: 6]);
      end
      if (fwd_pass) begin
         s_d.functional_pass_count = f_dn(s_d.functional_pass_count, s_q.mon_cfg[wsv_pkg::FDEC_L +: 6]);
      end
      if (tec_dec) begin
         s_d.total_error_count = f_dn(s_d.total_error_count, s_q.tec_cfg[wsv_pkg::DEC_L +: 6]);
      end
      any_ovf = (wwd_err & up_w[6]) | (hb & up_f[6]) | (tec_inc & up_t[6]);

      // ==========================================================
      // reset counter and watchdog reset pulse
      do_rst = any_ovf & s_q.cfg_b[wsv_pkg::CFG_REN]
             & (s_q.rst_cnt != wsv_pkg::RC_FULL);
      if (do_rst) begin
         s_d.rst_cnt = 3'(s_q.rst_cnt + 3'h1);
         s_d.rst_tmr = wsv_pkg::RST_LOAD;
         s_d.window_error_count   = 6'h00;
         s_d.functional_pass_count   = 6'h00;
         s_d.total_error_count     = 6'h00;
      end else if (s_q.rst_tmr != '0) begin
         s_d.rst_tmr = s_q.rst_tmr - 1'b1;
      end

      // ==========================================================
      // operating state from the new counter values
      if (any_ovf | (s_d.rst_tmr != '0)) begin
         s_d.op = wsv_pkg::OP_WDRST;
      end else if ((s_d.window_error_count > wsv_pkg::SAFE_LIM)
                 | (s_d.functional_pass_count > wsv_pkg::SAFE_LIM)
                 | (s_d.total_error_count > wsv_pkg::SAFE_LIM)) begin
         s_d.op = wsv_pkg::OP_SAFE;
      end else begin
         s_d.op = wsv_pkg::OP_READY;
      end

      // ==========================================================
      // power-down counters; clear first so an increment still lands
      if ((s_d.op == wsv_pkg::OP_READY) & (s_q.op != wsv_pkg::OP_READY)) begin
         s_d.pd_w = 3'h0;
         s_d.pd_f = 3'h0;
         s_d.pd_t = 3'h0;
      end
      pw = f_pd(s_d.pd_w);
      pf = f_pd(s_d.pd_f);
      pt = f_pd(s_d.pd_t);
      pd_ovf = 1'b0;
      if (i_sw_reset | (wwd_err & up_w[6])) begin
         s_d.pd_w = pw[2:0];
         pd_ovf = pd_ovf | pw[3];
      end
      if (i_sw_reset | (hb & up_f[6])) begin
         s_d.pd_f = pf[2:0];
         pd_ovf = pd_ovf | pf[3];
      end
      if (i_sw_reset | (tec_inc & up_t[6])) begin
         s_d.pd_t = pt[2:0];
         pd_ovf = pd_ovf | pt[3];
      end

      // ==========================================================
      // secure shut-off timer; ignition high holds it cleared
      secure_shutoff_timer_exp = 1'b0;
      if (i_ignition) begin
         s_d.secure_shutoff_timer_run = 1'b0;
         s_d.secure_shutoff_timer_cnt = '0;
      end else if (s_q.secure_shutoff_timer_run) begin
         if (s_q.secure_shutoff_timer_cnt == SECURE_SHUTOFF_TIMER_CYCLES - 1'b1) begin
            secure_shutoff_timer_exp = 1'b1;
            s_d.secure_shutoff_timer_run = 1'b0;
            s_d.secure_shutoff_timer_cnt = '0;
         end else begin
            s_d.secure_shutoff_timer_cnt = s_q.secure_shutoff_timer_cnt + 1'b1;
         end
      end else if (any_ovf) begin
         s_d.secure_shutoff_timer_run = 1'b1;
      end

      // ==========================================================
      // outputs, all registered
      s_d.monitor   = (s_d.op == wsv_pkg::OP_READY);
      s_d.reset_n   = (s_d.rst_tmr == '0);
      s_d.stage_off = (s_d.op != wsv_pkg::OP_READY);
      s_d.pwrdn     = (pd_ovf & ~i_ignition) | secure_shutoff_timer_exp;

      // ==========================================================
      // synchronous reset values override everything above
      if (i_srst) begin
         s_d = '0;
         s_d.ready    = 1'b1;
         s_d.cfg_b    = wsv_pkg::CFGB_RST;
         s_d.tec_cfg  = wsv_pkg::TEC_RST;
         s_d.mon_cfg  = wsv_pkg::MON_RST;
         s_d.resp_cnt = wsv_pkg::BYTE3;
         s_d.q_seq    = 8'h00;
         s_d.chk      = wsv_pkg::CHK_CLEAN;
         s_d.op       = wsv_pkg::OP_READY;
         s_d.monitor  = 1'b1;
         s_d.reset_n  = 1'b1;
      end
   end

   // ==========================================================
   // registers
   always_ff @(posedge i_clk) begin
      s_q <= s_d;
   end

   // ==========================================================
   // ports straight from the state register
   assign o_hreadyout = s_q.ready;
   assign o_hresp     = s_q.hresp;
   assign o_hrdata    = s_q.rdata;
   assign o_monitor   = s_q.monitor;
   assign o_reset_n   = s_q.reset_n;
   assign o_stage_off = s_q.stage_off;
   assign o_powerdown = s_q.pwrdn;

endmodule

/* File: wsv_pkg.sv */
// constants and types of the watchdog error and reset supervisor
package wsv_pkg;

   // ==========================================================
   // timing
   localparam longint CLK_HZ   = 50_000_000;
   localparam longint SECURE_SHUTOFF_TIMER_MIN = 20;
   localparam longint SECURE_SHUTOFF_TIMER_CYC = SECURE_SHUTOFF_TIMER_MIN * 60 * CLK_HZ;
   localparam longint RST_US   = 1;
   localparam int     RST_CYC  = int'(RST_US * CLK_HZ / 1_000_000);
   localparam int     SECURE_SHUTOFF_TIMER_W   = 36;
   localparam int     RT_W     = 6;
   localparam logic [RT_W-1:0] RST_LOAD = RT_W'(RST_CYC);

   // ==========================================================
   // counter limits, first answer byte and bus word size
   localparam logic [5:0] SAFE_LIM = 6'h20;
   localparam logic [2:0] PD_FULL  = 3'h7;
   localparam logic [2:0] RC_FULL  = 3'h7;
   localparam logic [1:0] BYTE3    = 2'h3;
   localparam logic [2:0] HSIZE_W  = 3'h2;

   // ==========================================================
   // register byte offsets
   localparam logic [7:0] A_RESP  = 8'h00;
   localparam logic [7:0] A_RSYNC = 8'h04;
   localparam logic [7:0] A_HSYNC = 8'h08;
   localparam logic [7:0] A_CFGB  = 8'h0C;
   localparam logic [7:0] A_TECFG = 8'h10;
   localparam logic [7:0] A_MNCFG = 8'h14;
   localparam logic [7:0] A_FSTB  = 8'h18;
   localparam logic [7:0] A_TEST  = 8'h1C;
   localparam logic [7:0] A_STA   = 8'h20;
   localparam logic [7:0] A_STB   = 8'h24;

   // ==========================================================
   // fields and reset values
   localparam int CFG_QG  = 0;
   localparam int CFG_REN = 1;
   localparam logic [1:0]  CFGB_RST  = 2'h2;
   localparam logic [31:0] TEC_MASK  = 32'h0000_3F3F;
   localparam logic [31:0] MON_MASK  = 32'h3F3F_3F3F;
   localparam logic [31:0] TEC_RST   = 32'h0000_0101;
   localparam logic [31:0] MON_RST   = 32'h0101_0101;
   localparam int INC_L = 0;
   localparam int DEC_L = 8;
   localparam int FINC_L = 16;
   localparam int FDEC_L = 24;

   // ==========================================================
   // expected answers, {byte3, byte2, byte1, byte0} per question
   localparam logic [31:0] RESP_TAB [16] = '{
      32'hFF0FF000, 32'hB040BF4F, 32'hE919E616, 32'hA656A959,
      32'h75857A8A, 32'h3ACA35C5, 32'h63936C9C, 32'h2CDC23D3,
      32'hD222DD2D, 32'h9D6D9262, 32'hC434CB3B, 32'h8B7B8474,
      32'h58A857A7, 32'h17E718E8, 32'h4EBE41B1, 32'h01F10EFE};

   // short sequence: gray value then its complement, distance >= 3
   localparam logic [3:0] QSEQ [16] = '{
      4'h0, 4'hF, 4'h1, 4'hE, 4'h3, 4'hC, 4'h2, 4'hD,
      4'h6, 4'h9, 4'h7, 4'h8, 4'h5, 4'hA, 4'h4, 4'hB};

   typedef enum logic [1:0] {
      OP_READY = 2'b00,
      OP_SAFE  = 2'b01,
      OP_WDRST = 2'b11
   } wsv_op_t;

   typedef enum logic {
      CHK_CLEAN = 1'b0,
      CHK_PEND  = 1'b1
   } wsv_chk_t;

endpackage

/* File: wsv_supervisor_asserts.sv */
// output checker of the watchdog error and reset supervisor
`timescale 1ns/1ps
module wsv_supervisor_asserts (
   input wire logic i_clk,
   input wire logic i_srst,
   input wire logic i_ignition,
   input wire logic o_monitor,
   input wire logic o_reset_n,
   input wire logic o_stage_off,
   input wire logic o_powerdown
);
   // ==========
   // length of the running reset pulse, saturating
   logic [6:0] low_q;
   logic [6:0] low_d;

   always_comb begin
      low_d = 7'h00;
      if (!o_reset_n) begin
         low_d = (low_q == 7'h7F) ? low_q : low_q + 7'h01;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         low_q <= 7'h00;
      end else begin
         low_q <= low_d;
      end
   end

   // ==========
   // assertions
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_srst);

   a_mon_stage: assert property (
      o_monitor != o_stage_off) else $error("monitor and stage off agree");
   a_mon_rst: assert property (
      o_monitor |-> o_reset_n) else $error("ready with reset low");
   a_rst_outputs: assert property (
      !o_reset_n |-> !o_monitor && o_stage_off)
      else $error("reset low while stages enabled");
   a_rst_len: assert property (
      $rose(o_reset_n) |-> int'(low_q) == wsv_pkg::RST_CYC)
      else $error("reset pulse length wrong");
   a_rst_cap: assert property (
      int'(low_q) <= wsv_pkg::RST_CYC) else $error("reset pulse too long");
   a_rst_recover: assert property (
      $rose(o_reset_n) |-> ##[0:2] o_monitor)
      else $error("counters not cleared after reset");
   a_pd_pulse: assert property (
      o_powerdown |=> !o_powerdown) else $error("power-down not a pulse");
   a_pd_ign: assert property (
      o_powerdown |-> !$past(i_ignition))
      else $error("power-down with ignition on");

   c_reset: cover property (!o_reset_n ##1 o_reset_n);
   c_pdown: cover property (o_powerdown);
   c_safe: cover property ($fell(o_monitor) && o_reset_n);
endmodule

bind wsv_supervisor wsv_supervisor_asserts u_chk (
   .i_clk(i_clk), .i_srst(i_srst), .i_ignition(i_ignition),
   .o_monitor(o_monitor), .o_reset_n(o_reset_n),
   .o_stage_off(o_stage_off), .o_powerdown(o_powerdown));

/* File: wsv_mcu_model.sv */
// microcontroller model: bus master sending watchdog answers
`timescale 1ns/1ps
module wsv_mcu_model (
   input  wire logic        i_clk,
   input  wire logic        i_hready,
   input  wire logic [31:0] i_hrdata,
   output logic             o_hsel,
   output logic [31:0]      o_haddr,
   output logic [1:0]       o_htrans,
   output logic             o_hwrite,
   output logic [2:0]       o_hsize,
   output logic [31:0]      o_hwdata,
   output logic             o_hung
);
   initial begin
      o_hsel = 1'b0;
      o_haddr = 32'h0;
      o_htrans = 2'h0;
      o_hwrite = 1'b0;
      o_hsize = wsv_pkg::HSIZE_W;
      o_hwdata = 32'h0;
      o_hung = 1'b0;
   end

   // ==========
   // one single word transfer; wait states are allowed for
   task automatic xfer(input logic [7:0] a, input logic w,
                       input logic [31:0] d, output logic [31:0] q);
      int n;
      n = 0;
      o_hsel <= 1'b1;
      o_haddr <= {24'h000000, a};
      o_htrans <= 2'h2;
      o_hwrite <= w;
      do begin
         @(posedge i_clk);
         n++;
      end while (!i_hready && n < 64);
      o_hsel <= 1'b0;
      o_htrans <= 2'h0;
      o_hwdata <= d;
      do begin
         @(posedge i_clk);
         n++;
      end while (!i_hready && n < 64);
      q = i_hrdata;
      // released data line must not keep looking valid
      o_hwdata <= ~d;
      if (n >= 64) begin
         o_hung <= 1'b1;
      end
   endtask

   // ==========
   // four answer bytes, optionally spaced, optionally wrong at byte 0
   task automatic answer(input logic [3:0] qn, input logic [7:0] a,
                         input bit bad, input int gap);
      logic [31:0] r;
      logic [31:0] x;
      for (int i = 3; i >= 0; i--) begin
         x = {24'h000000, wsv_pkg::RESP_TAB[qn][i*8 +: 8]};
         if (bad && i == 0) begin
            x[7:0] = ~x[7:0];
         end
         xfer(a, 1'b1, x, r);
         repeat (gap) @(posedge i_clk);
      end
   endtask
endmodule

/* File: wsv_supervisor_tb.sv */
// self-checking testbench of the watchdog error and reset supervisor
`timescale 1ns/1ps
module wsv_supervisor_tb;
   // ==========
   // signals
   logic        i_clk, i_srst, i_ignition, i_sw_reset, i_hb_expire;
   logic        i_window_error, i_window_pass;
   logic        hsel, hwrite, hreadyout, hresp, hung;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [31:0] haddr, hwdata, hrdata;
   logic        o_monitor, o_reset_n, o_stage_off, o_powerdown;
   int          fails;
   int          n_compared;

   // short shut-off time keeps the run brief
   wsv_supervisor #(.SECURE_SHUTOFF_TIMER_CYCLES(36'h0000000C8)) dut (
      .i_clk(i_clk), .i_srst(i_srst), .i_hsel(hsel), .i_haddr(haddr),
      .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize),
      .i_hwdata(hwdata), .i_hready(hreadyout), .o_hreadyout(hreadyout),
      .o_hresp(hresp), .o_hrdata(hrdata), .i_ignition(i_ignition),
      .i_sw_reset(i_sw_reset), .i_hb_expire(i_hb_expire),
      .i_window_error(i_window_error), .i_window_pass(i_window_pass),
      .o_monitor(o_monitor), .o_reset_n(o_reset_n),
      .o_stage_off(o_stage_off), .o_powerdown(o_powerdown));

   wsv_mcu_model u_mcu (
      .i_clk(i_clk), .i_hready(hreadyout), .i_hrdata(hrdata),
      .o_hsel(hsel), .o_haddr(haddr), .o_htrans(htrans),
      .o_hwrite(hwrite), .o_hsize(hsize), .o_hwdata(hwdata),
      .o_hung(hung));

   // ==========
   // shared tasks
   task automatic chk(input string nm, input logic [31:0] seen,
                      input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         fails++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic close_out;
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic give_up(input int n, input int lim);
      if (n >= lim) begin
         fails++;
         close_out();
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      u_mcu.xfer(a, 1'b1, d, r);
   endtask

   // status settles a cycle after a command, so idle first
   task automatic rchk(input string nm, input logic [7:0] a,
                       input logic [31:0] m, input logic [31:0] e);
      logic [31:0] r;
      repeat (2) @(posedge i_clk);
      u_mcu.xfer(a, 1'b0, 32'h0, r);
      chk(nm, r & m, e);
   endtask

   // ==========
   // scenarios
   task automatic t_reset;
      rchk("question", wsv_pkg::A_FSTB, 32'h3F, 32'h30);
      rchk("state", wsv_pkg::A_STB, 32'hFFFFFFFF, 32'h0);
      chk("monitor", o_monitor, 32'h1);
      $display("t_reset done");
   endtask

   task automatic t_answer;
      u_mcu.answer(4'h0, wsv_pkg::A_RESP, 1'b0, 0);
      rchk("next q", wsv_pkg::A_FSTB, 32'h3F, 32'h3F);
      u_mcu.answer(4'hF, wsv_pkg::A_RSYNC, 1'b0, 3);
      rchk("next q", wsv_pkg::A_FSTB, 32'h3F, 32'h31);
      rchk("tec floor", wsv_pkg::A_TEST, 32'h3F, 32'h0);
      u_mcu.answer(4'h1, wsv_pkg::A_RESP, 1'b1, 0);
      rchk("kept q", wsv_pkg::A_FSTB, 32'h3F, 32'h31);
      i_hb_expire <= 1'b1;
      @(posedge i_clk);
      i_hb_expire <= 1'b0;
      rchk("tec pend", wsv_pkg::A_TEST, 32'h3F, 32'h1);
      u_mcu.answer(4'h1, wsv_pkg::A_RSYNC, 1'b0, 0);
      rchk("tec dec", wsv_pkg::A_TEST, 32'h3F, 32'h0);
      wr(wsv_pkg::A_RESP, 32'h4E);
      rchk("byte cnt", wsv_pkg::A_FSTB, 32'h3F, 32'h2E);
      wr(wsv_pkg::A_HSYNC, 32'h0);
      rchk("byte cnt", wsv_pkg::A_FSTB, 32'h30, 32'h30);
      rchk("tec sync", wsv_pkg::A_TEST, 32'h3F, 32'h1);
      $display("t_answer done");
   endtask

   task automatic t_swreset;
      i_sw_reset <= 1'b1;
      @(posedge i_clk);
      i_sw_reset <= 1'b0;
      rchk("pd b", wsv_pkg::A_STB, 32'h77, 32'h11);
      rchk("pd a", wsv_pkg::A_STA, 32'h70, 32'h10);
      $display("t_swreset done");
   endtask

   task automatic t_count;
      int n;
      i_ignition <= 1'b0;
      wr(wsv_pkg::A_TECFG, 32'h0000013E);
      wr(wsv_pkg::A_HSYNC, 32'h0);
      rchk("tec", wsv_pkg::A_TEST, 32'h3F, 32'h3F);
      chk("monitor", o_monitor, 32'h0);
      chk("stage off", o_stage_off, 32'h1);
      wr(wsv_pkg::A_HSYNC, 32'h0);
      n = 0;
      while (o_reset_n !== 1'b0 && n < 20) begin
         @(posedge i_clk);
         n++;
      end
      give_up(n, 20);
      rchk("resets", wsv_pkg::A_STA, 32'h7, 32'h1);
      n = 0;
      while (o_reset_n !== 1'b1 && n < 100) begin
         @(posedge i_clk);
         n++;
      end
      give_up(n, 100);
      rchk("tec clr", wsv_pkg::A_TEST, 32'h3F, 32'h0);
      rchk("pd clr", wsv_pkg::A_STB, 32'h777, 32'h400);
      chk("monitor", o_monitor, 32'h1);
      n = 0;
      while (o_powerdown !== 1'b1 && n < 300) begin
         @(posedge i_clk);
         n++;
      end
      give_up(n, 300);
      chk("powerdown", o_powerdown, 32'h1);
      i_ignition <= 1'b1;
      $display("t_count done");
   endtask

   task automatic t_norst;
      wr(wsv_pkg::A_CFGB, 32'h0);
      wr(wsv_pkg::A_HSYNC, 32'h0);
      wr(wsv_pkg::A_HSYNC, 32'h0);
      repeat (3) @(posedge i_clk);
      chk("no reset", o_reset_n, 32'h1);
      rchk("resets", wsv_pkg::A_STA, 32'h7, 32'h1);
      rchk("tec held", wsv_pkg::A_TEST, 32'h3F, 32'h3E);
      $display("t_norst done");
   endtask

   // sixteen passes in long mode must not return to the start question
   task automatic t_long;
      logic [31:0] r;
      logic [3:0]  q0;
      wr(wsv_pkg::A_CFGB, 32'h3);
      u_mcu.xfer(wsv_pkg::A_FSTB, 1'b0, 32'h0, r);
      q0 = r[3:0];
      for (int k = 0; k < 16; k++) begin
         u_mcu.xfer(wsv_pkg::A_FSTB, 1'b0, 32'h0, r);
         u_mcu.answer(r[3:0], wsv_pkg::A_RESP, 1'b0, 0);
      end
      u_mcu.xfer(wsv_pkg::A_FSTB, 1'b0, 32'h0, r);
      chk("long order", 32'(r[3:0] != q0), 32'h1);
      $display("t_long done");
   endtask

   task automatic t_window;
      wr(wsv_pkg::A_TECFG, 32'h0000_0101);
      i_window_error <= 1'b1;
      @(posedge i_clk);
      i_window_error <= 1'b0;
      rchk("wwd up", wsv_pkg::A_STA, 32'h3F00, 32'h0100);
      u_mcu.answer(4'h0, wsv_pkg::A_RSYNC, 1'b1, 0);
      rchk("tec err", wsv_pkg::A_TEST, 32'h3F, 32'h3F);
      i_window_pass <= 1'b1;
      @(posedge i_clk);
      i_window_pass <= 1'b0;
      rchk("wwd down", wsv_pkg::A_STA, 32'h3F00, 32'h0);
      $display("t_window done");
   endtask

   // ==========
   // clock, reset and sequence
   always #10 i_clk = ~i_clk;

   always @(posedge i_clk) begin
      if (hung === 1'b1) begin
         fails++;
         close_out();
      end
   end

   initial begin
      i_clk = 1'b0;
      i_srst = 1'b1;
      i_ignition = 1'b1;
      i_sw_reset = 1'b0;
      i_hb_expire = 1'b0;
      i_window_error = 1'b0;
      i_window_pass = 1'b0;
      fails = 0;
      n_compared = 0;
      repeat (3) @(posedge i_clk);
      i_srst <= 1'b0;
      t_reset();
      t_answer();
      t_swreset();
      t_count();
      t_norst();
      t_long();
      t_window();
      close_out();
   end
endmodule
